// >>> hw/strap_regs_pkg.sv
// package: register offsets, field positions, reset codes, carriers
// assumes: used by strap_regs and mode_select; nothing imported
package strap_regs_pkg;
  // ************************************************************
  // register map (mmd register index inside device 2h)
  // ************************************************************
  localparam logic [15:0] OFS_OVERRIDE = 16'h0002;
  localparam logic [15:0] OFS_STATUS = 16'h0003;
  localparam logic [15:0] OFS_CTRL_SKEW = 16'h0004;
  localparam logic [15:0] OFS_CLK_SKEW = 16'h0008;
  localparam logic [15:0] OFS_WAKE_CTRL = 16'h0010;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_PWRDN = 7;
  localparam int BIT_NAND = 4;
  localparam int BIT_GMII = 1;
  localparam int BIT_EVT_EN = 8;
  localparam int SEL_LSB = 14;
  localparam int RXDV_LSB = 4;
  localparam int TXEN_LSB = 0;
  localparam int GTX_LSB = 5;
  localparam int RXC_LSB = 0;

  // ************************************************************
  // reset values and writable masks
  // ************************************************************
  localparam logic [3:0] RST_CTRL_CODE = 4'h7;
  localparam logic [4:0] RST_CLK_CODE = 5'h0F;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [15:0] MASK_OVERRIDE = 16'h0192;
  localparam logic [15:0] MASK_CTRL_SKEW = 16'h00FF;
  localparam logic [15:0] MASK_CLK_SKEW = 16'h03FF;
  localparam logic [15:0] MASK_WAKE_CTRL = 16'hC000;

  // output-select encodings of the shared pin
  localparam logic [1:0] SEL_EVENT = 2'h0;
  localparam logic [1:0] SEL_LED = 2'h1;
  localparam logic [1:0] SEL_BOTH = 2'h2;

  // skew codes delivered to the pad delay cells
  typedef struct packed {
    logic [3:0] rx_dv;
    logic [3:0] tx_en;
    logic [4:0] gtx_clk;
    logic [4:0] rx_clk;
  } skew_type;

  // operating mode as applied (strap or override)
  typedef struct packed {
    logic pwrdn;
    logic nand_tree;
    logic gmii;
  } mode_type;
endpackage

// >>> hw/mode_select.sv
// holds the shared led / wake-event pin mux
// assumes: inputs come from registers on the same clock
module mode_select (
  input wire logic core_clk_in, // management clock
  input wire logic rstn_in, // async reset, active low
  input wire logic evt_en_in, // event output enable bit
  input wire logic [1:0] sel_in, // output-select field
  input wire logic led_in, // led indication level
  input wire logic wake_n_in, // wake event, active low
  output logic indicator_out_a, // shared pin, led function
  output logic wake_event_out_a // shared pin, event function, active low
);
  logic nxt_led;
  logic nxt_wake;
  logic led_ff;
  logic wake_ff;

  // reserved select code parks both functions inactive
  always_comb begin
    nxt_led = 1'b0;
    nxt_wake = 1'b1;
    unique case (sel_in)
      strap_regs_pkg::SEL_EVENT: nxt_wake = evt_en_in ? wake_n_in : 1'b1; // [RULE_02] [RULE_03]
      strap_regs_pkg::SEL_LED: nxt_led = led_in; // [RULE_03]
      strap_regs_pkg::SEL_BOTH: begin
        nxt_led = led_in; // [RULE_03]
        nxt_wake = evt_en_in ? wake_n_in : 1'b1; // [RULE_01]
      end
      default: nxt_led = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      led_ff <= 1'b0;
      wake_ff <= 1'b1;
    end else begin
      led_ff <= nxt_led;
      wake_ff <= nxt_wake;
    end
  end

  assign indicator_out_a = led_ff;
  assign wake_event_out_a = wake_ff;

  a_event_gated: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_01]
    !evt_en_in |=> wake_ff)
    else $error("event pin active while disabled");
  a_led_only: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_03]
    (sel_in == strap_regs_pkg::SEL_LED) |=> (wake_ff && led_ff == $past(led_in)))
    else $error("led-only select wrong");
endmodule

// >>> hw/strap_regs.sv
// strap override, strap status and pad skew registers with pin mux
// assumes: indirect mmd access decoded upstream into reg strobes on core_clk_in
// Behaviour
// (RULE_01) override bit 8 enables wake-event output on shared pin, default zero
// (RULE_02) shared pin function from enable bit and wake-control bits 15:14
// (RULE_03) select 00 event only, 01 led only, 10 both, 11 reserved
// (RULE_04) override bit 7 makes power-down follow register not strap
// (RULE_05) strap-related reset values come from sampled mode strap pins
// (RULE_06) override bit 4 makes nand-tree follow register not strap
// (RULE_07) override bit 1 makes gmii/mii mode follow register not strap
// (RULE_08) status bit 7 shows strapped power-down; upper byte reads zero
// (RULE_09) status bit 4 shows strapped nand-tree mode
// (RULE_10) status bit 1 shows strapped gmii/mii mode
// (RULE_11) control skew bits 7:4 rx data-valid delay, reset 0111
// (RULE_12) control skew bits 3:0 tx enable delay, reset 0111
// (RULE_13) clock skew bits 9:5 gtx clock delay, reset 01111
// (RULE_14) clock skew bits 4:0 rx clock delay, reset 01111
// (RULE_15) skew codes drive pads steadily; reserved bits ignore writes, read zero
module strap_regs (
  input wire logic core_clk_in, // management clock, 25 mhz
  input wire logic rstn_in, // async reset, active low
  input wire logic [3:0] mode_strap_in, // mode strap pins, raw
  input wire logic reg_wr_in, // register write strobe
  input wire logic reg_rd_in, // register read strobe
  input wire logic [15:0] reg_addr_in, // mmd register index
  input wire logic [15:0] reg_wdata_in, // write data
  input wire logic led_in, // led indication level
  input wire logic wake_n_in, // wake event, active low
  output logic [15:0] reg_rdata_out, // read data, valid after rd strobe
  output strap_regs_pkg::skew_type skew_out, // pad delay codes
  output strap_regs_pkg::mode_type mode_out, // applied operating mode
  output logic indicator_out_a, // shared pin, led function
  output logic wake_event_out_a // shared pin, event function
);
  // ************************************************************
  // strap capture
  // ************************************************************
  logic [3:0] strap_s1_ff;
  logic [3:0] strap_s2_ff;
  logic [1:0] cap_cnt_ff;
  logic [1:0] nxt_cap_cnt;
  logic cap_done;
  logic [2:0] strap_ff;
  logic [2:0] nxt_strap;

  // pins are asynchronous: two flops before use
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strap_s1_ff <= 4'h0;
      strap_s2_ff <= 4'h0;
    end else begin
      strap_s1_ff <= mode_strap_in;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // latch once the synchroniser has settled after release
  assign cap_done = (cap_cnt_ff == 2'h3);
  always_comb begin
    nxt_cap_cnt = cap_done ? cap_cnt_ff : cap_cnt_ff + 2'h1;
    nxt_strap = strap_ff;
    if (cap_cnt_ff == 2'h2) begin
      // decode of mode pins: bit3 power-down, bit2 nand, bit1 gmii select, bit0 unused
      nxt_strap = {strap_s2_ff[3], strap_s2_ff[2], strap_s2_ff[1]}; // [RULE_05]
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cap_cnt_ff <= 2'h0;
      strap_ff <= 3'h0;
    end else begin
      cap_cnt_ff <= nxt_cap_cnt;
      strap_ff <= nxt_strap;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] ovr_ff;
  logic [15:0] nxt_ovr;
  logic [15:0] cskew_ff;
  logic [15:0] nxt_cskew;
  logic [15:0] kskew_ff;
  logic [15:0] nxt_kskew;
  logic [15:0] wake_ctl_ff;
  logic [15:0] nxt_wake_ctl;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] status_val;
  logic [15:0] strap_vec;
  logic wr_ovr;

  assign wr_ovr = reg_wr_in && (reg_addr_in == strap_regs_pkg::OFS_OVERRIDE);
  assign strap_vec = (16'h0000 | ({15'h0000, strap_ff[2]} << strap_regs_pkg::BIT_PWRDN)
    | ({15'h0000, strap_ff[1]} << strap_regs_pkg::BIT_NAND)
    | ({15'h0000, strap_ff[0]} << strap_regs_pkg::BIT_GMII));
  // status is read-only; upper byte and reserved bits fixed at zero
  assign status_val = strap_vec; // [RULE_08] [RULE_09] [RULE_10]

  // write path; reserved bits masked so they stay zero
  always_comb begin
    nxt_ovr = ovr_ff;
    nxt_cskew = cskew_ff;
    nxt_kskew = kskew_ff;
    nxt_wake_ctl = wake_ctl_ff;
    // override bits take strap defaults at capture, unless software writes the override register in that same cycle
    if (cap_cnt_ff == 2'h2 && !wr_ovr) begin
      nxt_ovr[strap_regs_pkg::BIT_PWRDN] = strap_s2_ff[3]; // [RULE_05]
      nxt_ovr[strap_regs_pkg::BIT_NAND] = strap_s2_ff[2]; // [RULE_05]
      nxt_ovr[strap_regs_pkg::BIT_GMII] = strap_s2_ff[1]; // [RULE_05]
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        strap_regs_pkg::OFS_OVERRIDE:
          nxt_ovr = reg_wdata_in & strap_regs_pkg::MASK_OVERRIDE; // [RULE_01] [RULE_15]
        strap_regs_pkg::OFS_CTRL_SKEW:
          nxt_cskew = reg_wdata_in & strap_regs_pkg::MASK_CTRL_SKEW; // [RULE_11] [RULE_12]
        strap_regs_pkg::OFS_CLK_SKEW:
          nxt_kskew = reg_wdata_in & strap_regs_pkg::MASK_CLK_SKEW; // [RULE_13] [RULE_14]
        strap_regs_pkg::OFS_WAKE_CTRL:
          nxt_wake_ctl = reg_wdata_in & strap_regs_pkg::MASK_WAKE_CTRL; // [RULE_02]
        default: nxt_wake_ctl = wake_ctl_ff;
      endcase
    end
  end

  // read path; unmapped index reads zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        strap_regs_pkg::OFS_OVERRIDE: nxt_rdata = ovr_ff;
        strap_regs_pkg::OFS_STATUS: nxt_rdata = status_val;
        strap_regs_pkg::OFS_CTRL_SKEW: nxt_rdata = cskew_ff;
        strap_regs_pkg::OFS_CLK_SKEW: nxt_rdata = kskew_ff;
        strap_regs_pkg::OFS_WAKE_CTRL: nxt_rdata = wake_ctl_ff;
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovr_ff <= 16'h0000;
      cskew_ff <= {8'h00, strap_regs_pkg::RST_CTRL_CODE, strap_regs_pkg::RST_CTRL_CODE};
      kskew_ff <= {6'h00, strap_regs_pkg::RST_CLK_CODE, strap_regs_pkg::RST_CLK_CODE};
      wake_ctl_ff <= {strap_regs_pkg::RST_SEL, 14'h0000};
      rdata_ff <= 16'h0000;
    end else begin
      ovr_ff <= nxt_ovr;
      cskew_ff <= nxt_cskew;
      kskew_ff <= nxt_kskew;
      wake_ctl_ff <= nxt_wake_ctl;
      rdata_ff <= nxt_rdata;
    end
  end
  assign reg_rdata_out = rdata_ff;

  // ************************************************************
  // applied mode and pad codes
  // ************************************************************
  strap_regs_pkg::mode_type nxt_mode;
  strap_regs_pkg::mode_type mode_ff;
  strap_regs_pkg::skew_type skew_ff;
  strap_regs_pkg::skew_type nxt_skew;

  // override bit set: register value rules; clear: strap rules
  always_comb begin
    nxt_mode.pwrdn = ovr_ff[strap_regs_pkg::BIT_PWRDN] ? 1'b1 : strap_ff[2]; // [RULE_04]
    nxt_mode.nand_tree = ovr_ff[strap_regs_pkg::BIT_NAND] ? 1'b1 : strap_ff[1]; // [RULE_06]
    nxt_mode.gmii = ovr_ff[strap_regs_pkg::BIT_GMII] ? 1'b1 : strap_ff[0]; // [RULE_07]
    // codes held steadily; no glitch since they come from flops
    nxt_skew.rx_dv = cskew_ff[strap_regs_pkg::RXDV_LSB +: 4]; // [RULE_11] [RULE_15]
    nxt_skew.tx_en = cskew_ff[strap_regs_pkg::TXEN_LSB +: 4]; // [RULE_12]
    nxt_skew.gtx_clk = kskew_ff[strap_regs_pkg::GTX_LSB +: 5]; // [RULE_13]
    nxt_skew.rx_clk = kskew_ff[strap_regs_pkg::RXC_LSB +: 5]; // [RULE_14]
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_ff <= '0;
      skew_ff <= {strap_regs_pkg::RST_CTRL_CODE, strap_regs_pkg::RST_CTRL_CODE,
        strap_regs_pkg::RST_CLK_CODE, strap_regs_pkg::RST_CLK_CODE};
    end else begin
      mode_ff <= nxt_mode;
      skew_ff <= nxt_skew;
    end
  end
  assign mode_out = mode_ff;
  assign skew_out = skew_ff;

  // shared led / wake-event pin
  mode_select u_mux (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .evt_en_in(ovr_ff[strap_regs_pkg::BIT_EVT_EN]),
    .sel_in(wake_ctl_ff[strap_regs_pkg::SEL_LSB +: 2]),
    .led_in(led_in),
    .wake_n_in(wake_n_in),
    .indicator_out_a(indicator_out_a),
    .wake_event_out_a(wake_event_out_a)
  );

  // ************************************************************
  // checks
  // ************************************************************
  a_status_upper: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_08]
    reg_rd_in && reg_addr_in == strap_regs_pkg::OFS_STATUS
    |=> reg_rdata_out[15:8] == 8'h00
    && reg_rdata_out[strap_regs_pkg::BIT_PWRDN] == $past(strap_ff[2]))
    else $error("status upper byte or power-down bit wrong");
  a_pwrdn_override: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_04]
    ovr_ff[strap_regs_pkg::BIT_PWRDN] |=> mode_out.pwrdn)
    else $error("power-down override ignored");
  a_nand_follow: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_06]
    !ovr_ff[strap_regs_pkg::BIT_NAND] |=> mode_out.nand_tree == $past(strap_ff[1]))
    else $error("nand mode wrong");
  a_gmii_override: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_07]
    ovr_ff[strap_regs_pkg::BIT_GMII] |=> mode_out.gmii)
    else $error("gmii override ignored");
  a_skew_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_13]
    reg_wr_in && reg_addr_in == strap_regs_pkg::OFS_CLK_SKEW
    |=> ##1 skew_out.gtx_clk == $past(reg_wdata_in[9:5], 2))
    else $error("gtx skew lost");
  a_rxc_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_14]
    reg_wr_in && reg_addr_in == strap_regs_pkg::OFS_CLK_SKEW
    |=> ##1 skew_out.rx_clk == $past(reg_wdata_in[4:0], 2))
    else $error("rx clk skew lost");
  a_ctrl_write: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_11]
    reg_wr_in && reg_addr_in == strap_regs_pkg::OFS_CTRL_SKEW
    |=> ##1 skew_out.rx_dv == $past(reg_wdata_in[7:4], 2)
    && skew_out.tx_en == $past(reg_wdata_in[3:0], 2))
    else $error("ctrl skew lost");
  a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_15]
    (ovr_ff & ~strap_regs_pkg::MASK_OVERRIDE) == 16'h0000 && cskew_ff[15:8] == 8'h00
    && (kskew_ff & ~strap_regs_pkg::MASK_CLK_SKEW) == 16'h0000)
    else $error("reserved bit set");
  a_strap_capture: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [RULE_05]
    cap_cnt_ff == 2'h2 |=> strap_ff == $past(strap_s2_ff[3:1]))
    else $error("strap capture");
endmodule

// >>> test/mgmt_model.sv
// station management controller model: register strobes on the mmd index
// assumes: indirect access decoded upstream of strap_regs into one-cycle strobes
module mgmt_model (
  input wire logic core_clk_in, // management clock
  input wire logic [15:0] rdata_in, // read data from the device
  output logic wr_out, // write strobe
  output logic rd_out, // read strobe
  output logic [15:0] addr_out, // register index
  output logic [15:0] wdata_out // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'h0000;
    wdata_out = 16'h0000;
  end
  // one request held across its taking edge; idle lines show the inverse, not stale data
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge core_clk_in);
    #1;
    wr_out = w;
    rd_out = ~w;
    addr_out = a;
    wdata_out = d;
    @(posedge core_clk_in);
    #1;
    q = rdata_in;
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

// >>> test/phy_strap_override_skew_regs_tb.sv
// testbench: strap override, strap status, pad skew and shared pin mux
// assumes: mgmt_model beside the device; 25 mhz clock
module phy_strap_override_skew_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic led = 1'b1;
  logic wake_n = 1'b0;
  logic [3:0] strap = 4'hE;
  logic wr, rd, ind, wev;
  logic [15:0] addr, wdata, rdata, q;
  strap_regs_pkg::skew_type skew;
  strap_regs_pkg::mode_type mode;
  int n_errors = 0;
  int n_checks = 0;
  typedef struct packed {logic [15:0] a; logic [15:0] d; logic [15:0] r; logic [2:0] m;} row_type;
  typedef struct packed {logic [1:0] sel; logic en; logic ind; logic wev;} pin_type;
  // ************************************************************
  // table of ordinary cases, loaded after a reset with straps low
  // ************************************************************
  row_type rows [8] = '{'{16'h0002, 16'h0080, 16'h0080, 3'h4},
    '{16'h0002, 16'h0010, 16'h0010, 3'h2}, '{16'h0002, 16'h0002, 16'h0002, 3'h1},
    '{16'h0002, 16'hFFFF, 16'h0192, 3'h7}, '{16'h0003, 16'hFFFF, 16'h0000, 3'h7},
    '{16'h0004, 16'hFFFF, 16'h00FF, 3'h7}, '{16'h0008, 16'hFFFF, 16'h03FF, 3'h7},
    '{16'h0005, 16'hFFFF, 16'h0000, 3'h7}};
  // led level high, wake asserted: each select code shows which function passes
  pin_type pins [5] = '{'{2'h0, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b1},
    '{2'h2, 1'b1, 1'b1, 1'b0}, '{2'h3, 1'b1, 1'b0, 1'b1}, '{2'h2, 1'b0, 1'b1, 1'b1}};
  initial begin
    forever #20 clk = ~clk;
  end
  strap_regs strap_regs_inst (.core_clk_in(clk), .rstn_in(rstn), .mode_strap_in(strap),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .led_in(led),
    .wake_n_in(wake_n), .reg_rdata_out(rdata), .skew_out(skew), .mode_out(mode),
    .indicator_out_a(ind), .wake_event_out_a(wev));
  mgmt_model mgmt_model_inst (.core_clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset with given straps; strap capture needs a few edges after release
  task automatic do_reset(input logic [3:0] s);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    strap = s;
    repeat (16) @(posedge clk);
    chk(18'(skew), {4'h7, 4'h7, 5'h0F, 5'h0F});
    chk(18'(mode), 18'h0);
    chk(18'(wev), 18'h1);
    #1;
    rstn = 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] dummy;
    mgmt_model_inst.access(1'b1, a, d, dummy);
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] r);
    mgmt_model_inst.access(1'b0, a, 16'h0000, r);
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    do_reset(4'hE);
    rd_reg(16'h0003, q);
    chk(18'(q), 18'h0092);
    rd_reg(16'h0002, q);
    chk(18'(q), 18'h0092);
    chk(18'(mode), 18'h7);
    $display("test strap capture done");
    do_reset(4'h0);
    rd_reg(16'h0003, q);
    chk(18'(q), 18'h0000);
    chk(18'(mode), 18'h0);
    rd_reg(16'h0002, q);
    chk(18'(q), 18'h0000);
    rd_reg(16'h0004, q);
    chk(18'(q), 18'h0077);
    rd_reg(16'h0008, q);
    chk(18'(q), 18'h01EF);
    rd_reg(16'h0010, q);
    chk(18'(q), 18'h0000);
    for (int i = 0; i < 8; i++) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, q);
      chk(18'(q), 18'(rows[i].r));
      chk(18'(mode), 18'(rows[i].m));
    end
    $display("test register table done");
    // odd codes expose swapped or shifted fields
    wr_reg(16'h0008, 16'h0155);
    wr_reg(16'h0004, 16'h00A5);
    repeat (2) @(posedge clk);
    chk(18'(skew), {4'hA, 4'h5, 5'h0A, 5'h15});
    $display("test skew fields done");
    for (int i = 0; i < 5; i++) begin
      wr_reg(16'h0002, {7'h00, pins[i].en, 8'h00});
      wr_reg(16'h0010, {pins[i].sel, 14'h0000});
      repeat (2) @(posedge clk);
      chk(18'(ind), 18'(pins[i].ind));
      chk(18'(wev), 18'(pins[i].wev));
    end
    $display("test shared pin done");
    close_out();
  end
endmodule
